// [hw/qci_pkg.sv]
// Package: register map, field positions and carrier types of the quadrature counter
package qci_pkg;

  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int NFLG = 8;

  // Register byte offsets, one aligned word each
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CLR = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_EN = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_C0CNT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_C0GRA = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_C0GRB = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_C0GRC = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_C1CNT = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_C1GRA = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_C1GRB = 8'h28;

  // Control register fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_MODE_W = 3;
  localparam int CTL_RUN0 = 4;
  localparam int CTL_CAPB0 = 5;
  localparam int CTL_CAP1 = 6;
  localparam int CTL_CLRC0 = 7;

  // Status, clear and enable bit positions
  localparam int FLG_C0A = 0;
  localparam int FLG_C0B = 1;
  localparam int FLG_C0C = 2;
  localparam int FLG_C0V = 3;
  localparam int FLG_C1A = 4;
  localparam int FLG_C1B = 5;
  localparam int FLG_C1V = 6;
  localparam int FLG_C1U = 7;
  localparam int STAT_DIR = 8;

  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic DIR_RST = 1'b1;

  typedef enum logic [2:0] {
    QCI_OFF = 3'h0,
    QCI_PH2 = 3'h2,
    QCI_PH3 = 3'h3,
    QCI_PH4 = 3'h4
  } qci_pmode_e;

  typedef logic [NFLG-1:0] qci_flags_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } qci_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } qci_apb_rsp_s;

endpackage : qci_pkg

// [hw/qci_phase_dec.sv]
// Encoder input synchroniser and two-phase count decoder
`timescale 1ns/1ps
module qci_phase_dec (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic pinA,
  input wire logic pinB,
  input wire qci_pkg::qci_pmode_e mode,
  output logic countUp,
  output logic countDown
);
  import qci_pkg::*;

  logic [1:0] syncA;
  logic [1:0] syncB;
  logic prevA;
  logic prevB;
  logic aRise, aFall, bRise, bFall, lvA, lvB;
  logic next_up, next_down;

  // Two stages per pin; stage 0 feeds only stage 1
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      syncA <= 2'h0;
      syncB <= 2'h0;
      prevA <= 1'b0;
      prevB <= 1'b0;
    end else begin
      syncA <= {syncA[0], pinA};
      syncB <= {syncB[0], pinB};
      prevA <= syncA[1];
      prevB <= syncB[1];
    end
  end

  // Edges from registered samples, so each edge lasts one cycle
  assign lvA = syncA[1];
  assign lvB = syncB[1];
  assign aRise = lvA & ~prevA;
  assign aFall = ~lvA & prevA;
  assign bRise = lvB & ~prevB;
  assign bFall = ~lvB & prevB;

  // Count table per mode; illegal mode codes never count
  always_comb begin
    next_up = 1'b0;
    next_down = 1'b0;
    case (mode)
      QCI_PH2: begin
        next_up = aFall & lvB;
        next_down = aFall & ~lvB;
      end
      QCI_PH3: begin
        next_up = aFall & lvB;
        next_down = bFall & lvA;
      end
      QCI_PH4: begin
        next_up = (bRise & lvA) | (bFall & ~lvA);
        next_down = (bFall & lvA) | (bRise & ~lvA);
      end
      default: begin
        next_up = 1'b0;
        next_down = 1'b0;
      end
    endcase
  end

  // Registered one-cycle count pulses
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      countUp <= 1'b0;
      countDown <= 1'b0;
    end else begin
      countUp <= next_up;
      countDown <= next_down;
    end
  end

  a_step_exclusive: assert property (@(posedge mclk) disable iff (!arst_n)
    !(countUp && countDown)) else $error("up and down pulse together");
  a_mode3_down: assert property (@(posedge mclk) disable iff (!arst_n)
    (mode == QCI_PH3 && bFall && lvA) |=> countDown && !countUp)
    else $error("mode 3 missed down count");
  a_mode4_aedge: assert property (@(posedge mclk) disable iff (!arst_n)
    (mode == QCI_PH4 && !bRise && !bFall) |=> !countUp && !countDown)
    else $error("mode 4 counted without B edge");

endmodule : qci_phase_dec

// [hw/qci_irq.sv]
// Sticky status flags, enables and per-channel prioritised requests
`timescale 1ns/1ps
module qci_irq (
  input wire logic mclk,
  input wire logic arst_n,
  input wire qci_pkg::qci_flags_t events,
  input wire qci_pkg::qci_flags_t clrMask,
  input wire qci_pkg::qci_flags_t enable,
  output qci_pkg::qci_flags_t status,
  output logic irq,
  output logic reqCh0,
  output logic reqCh1,
  output logic [1:0] srcCh0,
  output logic [1:0] srcCh1
);
  import qci_pkg::*;

  qci_flags_t next_status;
  qci_flags_t next_pend;

  // Lowest bit wins inside a channel's group of four
  function automatic logic [1:0] pickFirst(input logic [3:0] v);
    if (v[0]) return 2'h0;
    if (v[1]) return 2'h1;
    if (v[2]) return 2'h2;
    return 2'h3;
  endfunction : pickFirst

  // A new event beats a clear landing in the same cycle
  assign next_status = (status & ~clrMask) | events;
  assign next_pend = next_status & enable;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status <= '0;
      irq <= 1'b0;
      reqCh0 <= 1'b0;
      reqCh1 <= 1'b0;
      srcCh0 <= 2'h0;
      srcCh1 <= 2'h0;
    end else begin
      status <= next_status;
      irq <= |next_pend;
      reqCh0 <= |next_pend[FLG_C0V:FLG_C0A];
      reqCh1 <= |next_pend[FLG_C1U:FLG_C1A];
      srcCh0 <= pickFirst(next_pend[FLG_C0V:FLG_C0A]);
      srcCh1 <= pickFirst(next_pend[FLG_C1U:FLG_C1A]);
    end
  end

  a_flag_sticky: assert property (@(posedge mclk) disable iff (!arst_n)
    (events != '0) |=> ((status & $past(events)) == $past(events)))
    else $error("event did not set its flag");
  a_irq_level: assert property (@(posedge mclk) disable iff (!arst_n)
    1 |=> irq == |(status & $past(enable))) else $error("irq not status and enable");
  a_clear_drop: assert property (@(posedge mclk) disable iff (!arst_n)
    (clrMask == status && events == '0) |=> status == '0 && !irq)
    else $error("clear did not withdraw request");
  a_prio_ch1: assert property (@(posedge mclk) disable iff (!arst_n)
    1 |=> srcCh1 == pickFirst(status[FLG_C1U:FLG_C1A] & $past(enable[FLG_C1U:FLG_C1A])))
    else $error("channel 1 priority wrong");

endmodule : qci_irq

// [hw/qci_top.sv]
// Top: timebase channel, quadrature channel, capture links, APB registers and interrupts
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

module qci_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire qci_pkg::qci_apb_req_s apbReq,
  output qci_pkg::qci_apb_rsp_s apbRsp,
  input wire logic extClockPinA,
  input wire logic extClockPinB,
  output logic irq,
  output logic irqReqCh0,
  output logic irqReqCh1,
  output logic [1:0] irqSrcCh0,
  output logic [1:0] irqSrcCh1
);
  import qci_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [CTL_MODE_W-1:0] ctrlMode;
  logic run0;
  logic capB0;
  logic cap1;
  logic clrC0;
  qci_flags_t irqEnable;
  qci_flags_t irqStatus;
  qci_flags_t events;
  qci_flags_t clrMask;
  qci_pmode_e phaseMode;

  logic [CNT_W-1:0] ch0Cnt;
  logic [CNT_W-1:0] ch0GrA;
  logic [CNT_W-1:0] ch0GrB;
  logic [CNT_W-1:0] ch0GrC;
  logic [CNT_W-1:0] ch1Cnt;
  logic [CNT_W-1:0] ch1GrA;
  logic [CNT_W-1:0] ch1GrB;
  logic countDir;

  logic up1;
  logic down1;
  logic step1;
  logic matchA0;
  logic matchC0;
  logic clear0;
  logic ovf0;
  logic ovf1;
  logic udf1;
  logic capEvtB0;
  logic capEvtA1;
  logic capEvtB1;

  logic setup;
  logic wrAcc;
  logic mapped;
  logic [31:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Exact word match of the bus address against one register offset
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction : hit

  // Write strobe for one register, only on the completing access edge
  function automatic logic wrHit(input logic acc, input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
    return acc & hit(a, off);
  endfunction : wrHit

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave

  // Setup phase seen this cycle; the reply is ready in the access cycle
  assign setup = apbReq.psel & ~apbReq.penable;
  assign wrAcc = apbReq.psel & apbReq.penable & apbRsp.pready & apbReq.pwrite;

  // Address map check, unmapped words answer with an error
  always_comb begin
    mapped = 1'b0;
    case (apbReq.paddr)
      OFF_CTRL, OFF_STAT, OFF_CLR, OFF_EN: mapped = 1'b1;
      OFF_C0CNT, OFF_C0GRA, OFF_C0GRB, OFF_C0GRC: mapped = 1'b1;
      OFF_C1CNT, OFF_C1GRA, OFF_C1GRB: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Read data; the clear register is write-only and reads zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (apbReq.paddr)
      OFF_CTRL: begin
        next_rdata[CTL_MODE_LSB +: CTL_MODE_W] = ctrlMode;
        next_rdata[CTL_RUN0] = run0;
        next_rdata[CTL_CAPB0] = capB0;
        next_rdata[CTL_CAP1] = cap1;
        next_rdata[CTL_CLRC0] = clrC0;
      end
      OFF_STAT: begin
        next_rdata[NFLG-1:0] = irqStatus;
        next_rdata[STAT_DIR] = countDir;
      end
      OFF_EN: next_rdata[NFLG-1:0] = irqEnable;
      OFF_C0CNT: next_rdata[CNT_W-1:0] = ch0Cnt;
      OFF_C0GRA: next_rdata[CNT_W-1:0] = ch0GrA;
      OFF_C0GRB: next_rdata[CNT_W-1:0] = ch0GrB;
      OFF_C0GRC: next_rdata[CNT_W-1:0] = ch0GrC;
      OFF_C1CNT: next_rdata[CNT_W-1:0] = ch1Cnt;
      OFF_C1GRA: next_rdata[CNT_W-1:0] = ch1GrA;
      OFF_C1GRB: next_rdata[CNT_W-1:0] = ch1GrB;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Reply registered in the setup cycle so it stands for the whole access
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      apbRsp <= '0;
    end else begin
      apbRsp.pready <= setup;
      apbRsp.pslverr <= setup & ~mapped;
      apbRsp.prdata <= (setup & ~apbReq.pwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control and enable registers

  // Software steers the mode, the capture links and the counter clearing
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlMode <= QCI_OFF;
      run0 <= 1'b0;
      capB0 <= 1'b0;
      cap1 <= 1'b0;
      clrC0 <= 1'b0;
    end else if (wrHit(wrAcc, apbReq.paddr, OFF_CTRL)) begin
      ctrlMode <= apbReq.pwdata[CTL_MODE_LSB +: CTL_MODE_W];
      run0 <= apbReq.pwdata[CTL_RUN0];
      capB0 <= apbReq.pwdata[CTL_CAPB0];
      cap1 <= apbReq.pwdata[CTL_CAP1];
      clrC0 <= apbReq.pwdata[CTL_CLRC0];
    end
  end

  // One enable bit per source
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irqEnable <= '0;
    end else if (wrHit(wrAcc, apbReq.paddr, OFF_EN)) begin
      irqEnable <= apbReq.pwdata[NFLG-1:0];
    end
  end

  // Write-one-to-clear, a single-cycle mask into the flag logic
  assign clrMask = wrHit(wrAcc, apbReq.paddr, OFF_CLR) ? apbReq.pwdata[NFLG-1:0] : '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Channel 0 timebase

  // Compare matches only while the timebase runs
  assign matchA0 = run0 & (ch0Cnt == ch0GrA);
  assign matchC0 = run0 & (ch0Cnt == ch0GrC);
  assign clear0 = clrC0 & matchC0;
  assign ovf0 = run0 & ~clear0 & (ch0Cnt == CNT_MAX);

  // Counts mclk only; it has no mode field, so it cannot decode phases
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ch0Cnt <= CNT_ZERO;
    end else if (wrHit(wrAcc, apbReq.paddr, OFF_C0CNT)) begin
      ch0Cnt <= apbReq.pwdata[CNT_W-1:0];
    end else if (clear0) begin
      ch0Cnt <= CNT_ZERO;
    end else if (run0) begin
      ch0Cnt <= ch0Cnt + CNT_ONE;
    end
  end

  // Compare values written by software
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ch0GrA <= CNT_MAX;
      ch0GrC <= CNT_MAX;
    end else begin
      if (wrHit(wrAcc, apbReq.paddr, OFF_C0GRA)) begin
        ch0GrA <= apbReq.pwdata[CNT_W-1:0];
      end
      if (wrHit(wrAcc, apbReq.paddr, OFF_C0GRC)) begin
        ch0GrC <= apbReq.pwdata[CNT_W-1:0];
      end
    end
  end

  // Each quadrature step latches the running timebase count; the step does not clear the timebase
  assign capEvtB0 = capB0 & step1;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ch0GrB <= CNT_ZERO;
    end else if (capEvtB0) begin
      ch0GrB <= ch0Cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channel 1 quadrature counter

  // Illegal mode codes fall to the decoder's no-count branch
  assign phaseMode = qci_pmode_e'(ctrlMode);

  // Phase A from pin A, phase B from pin B
  qci_phase_dec u_dec (
    .mclk(mclk),
    .arst_n(arst_n),
    .pinA(extClockPinA),
    .pinB(extClockPinB),
    .mode(phaseMode),
    .countUp(up1),
    .countDown(down1)
  );

  assign step1 = up1 | down1;
  assign ovf1 = up1 & (ch1Cnt == CNT_MAX);
  assign udf1 = down1 & (ch1Cnt == CNT_ZERO);

  // A software write wins over a count step in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ch1Cnt <= CNT_ZERO;
    end else if (wrHit(wrAcc, apbReq.paddr, OFF_C1CNT)) begin
      ch1Cnt <= apbReq.pwdata[CNT_W-1:0];
    end else if (up1) begin
      ch1Cnt <= ch1Cnt + CNT_ONE;
    end else if (down1) begin
      ch1Cnt <= ch1Cnt - CNT_ONE;
    end
  end

  // Direction follows the latest step and holds between steps
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      countDir <= DIR_RST;
    end else if (up1) begin
      countDir <= 1'b1;
    end else if (down1) begin
      countDir <= 1'b0;
    end
  end

  // Control-cycle position samples taken from timebase matches
  assign capEvtA1 = cap1 & matchA0;
  assign capEvtB1 = cap1 & matchC0;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ch1GrA <= CNT_ZERO;
      ch1GrB <= CNT_ZERO;
    end else begin
      if (capEvtA1) begin
        ch1GrA <= ch1Cnt;
      end
      if (capEvtB1) begin
        ch1GrB <= ch1Cnt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts

  // Capture/match and overflow sources in both channels, underflow in channel 1 only
  always_comb begin
    events = '0;
    events[FLG_C0A] = matchA0;
    events[FLG_C0B] = capEvtB0;
    events[FLG_C0C] = matchC0;
    events[FLG_C0V] = ovf0;
    events[FLG_C1A] = capEvtA1;
    events[FLG_C1B] = capEvtB1;
    events[FLG_C1V] = ovf1;
    events[FLG_C1U] = udf1;
  end

  qci_irq u_irq (
    .mclk(mclk),
    .arst_n(arst_n),
    .events(events),
    .clrMask(clrMask),
    .enable(irqEnable),
    .status(irqStatus),
    .irq(irq),
    .reqCh0(irqReqCh0),
    .reqCh1(irqReqCh1),
    .srcCh0(irqSrcCh0),
    .srcCh1(irqSrcCh1)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  a_ovf_wrap: assert property (@(posedge mclk) disable iff (!arst_n)
    (ovf1 && !wrHit(wrAcc, apbReq.paddr, OFF_C1CNT))
    |=> ch1Cnt == CNT_ZERO && irqStatus[FLG_C1V]) else $error("overflow wrap wrong");
  a_udf_wrap: assert property (@(posedge mclk) disable iff (!arst_n)
    (udf1 && !wrHit(wrAcc, apbReq.paddr, OFF_C1CNT))
    |=> ch1Cnt == CNT_MAX && irqStatus[FLG_C1U]) else $error("underflow wrap wrong");
  a_up_step: assert property (@(posedge mclk) disable iff (!arst_n)
    (up1 && !wrHit(wrAcc, apbReq.paddr, OFF_C1CNT))
    |=> ch1Cnt == $past(ch1Cnt) + CNT_ONE) else $error("up step not one");
  a_dir_flag: assert property (@(posedge mclk) disable iff (!arst_n)
    down1 |=> !countDir ##1 (countDir == $past(up1) || !$past(up1)))
    else $error("direction flag wrong");
  a_cap_ch1: assert property (@(posedge mclk) disable iff (!arst_n)
    (cap1 && matchA0) |=> ch1GrA == $past(ch1Cnt) && irqStatus[FLG_C1A])
    else $error("channel 1 capture A wrong");
  a_cap_ch0: assert property (@(posedge mclk) disable iff (!arst_n)
    (capB0 && step1) |=> ch0GrB == $past(ch0Cnt)) else $error("step width capture wrong");
  a_no_mode: assert property (@(posedge mclk) disable iff (!arst_n)
    (ctrlMode == QCI_OFF) [*3] |-> !step1) else $error("count without phase mode");

endmodule : qci_top

// [tb/qci_enc_model.sv]
// Encoder model: drives the two phase pins, one level change per call
`timescale 1ns/1ps
module qci_enc_model (
  input wire logic mclk,
  output logic pinA,
  output logic pinB
);

  // Both phases idle low at time zero
  initial begin
    pinA = 1'b0;
    pinB = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Levels change just after an edge and then hold for 8 cycles.
  // Shorter pulses could be lost in the two-flop synchroniser.
  task automatic move(input logic a, input logic b);
    @(posedge mclk);
    pinA <= a;
    pinB <= b;
    repeat (8) @(posedge mclk);
  endtask : move

endmodule : qci_enc_model

// [tb/tb_qci_top.sv]
// Testbench: APB driven checks of phase counting, captures and interrupt flags
`timescale 1ns/1ps
module tb_qci_top;
  import qci_pkg::*;
  logic mclk;
  logic arst_n;
  qci_apb_req_s apbReq;
  qci_apb_rsp_s apbRsp;
  logic pinA;
  logic pinB;
  logic irq;
  logic irqReqCh0;
  logic irqReqCh1;
  logic [1:0] irqSrcCh0;
  logic [1:0] irqSrcCh1;
  int nFail;
  int totalChecks;
  logic [31:0] rdata;
  logic rerr;
  logic [15:0] expCnt;
  // Pin walk {A,B}: each single-pin edge at both levels of the other pin
  logic [1:0] seqAB [8] = '{2'b01, 2'b11, 2'b10, 2'b00, 2'b10, 2'b11, 2'b01, 2'b00};
  int modeTab [4] = '{0, 2, 3, 4};
  int dlt [4][8] = '{'{0, 0, 0, 0, 0, 0, 0, 0}, '{0, 0, 0, -1, 0, 0, 1, 0},
                     '{0, 0, -1, 0, 0, 0, 1, 0}, '{-1, 0, -1, 0, 0, 1, 0, 1}};

  // Free running 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  qci_top i_qci_top (
    .mclk(mclk),
    .arst_n(arst_n),
    .apbReq(apbReq),
    .apbRsp(apbRsp),
    .extClockPinA(pinA),
    .extClockPinB(pinB),
    .irq(irq),
    .irqReqCh0(irqReqCh0),
    .irqReqCh1(irqReqCh1),
    .irqSrcCh0(irqSrcCh0),
    .irqSrcCh1(irqSrcCh1)
  );

  qci_enc_model i_qci_enc_model (
    .mclk(mclk),
    .pinA(pinA),
    .pinB(pinB)
  );

  ////////////////////////////////////////////////////////////////////////////////

  // Single place where the run ends
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Four-state compare so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    if (apbRsp.pready !== 1'b1) begin
      nFail++;
      give_verdict();
    end else begin
      rdata = apbRsp.prdata;
      rerr = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdata, e);
  endtask : rd

  // Request outputs packed as {irq, req0, req1, src0, src1}, after they settle.
  // An enable write lands one edge before the request flops see it, so wait
  // one full edge and look mid-cycle, away from the launching edge.
  task automatic irqChk(input logic [6:0] e);
    @(posedge mclk);
    @(negedge mclk);
    chk({25'h0, irq, irqReqCh0, irqReqCh1, irqSrcCh0, irqSrcCh1}, {25'h0, e});
  endtask : irqChk

  ////////////////////////////////////////////////////////////////////////////////

  // Main sequence
  initial begin
    apbReq = '0;
    arst_n = 1'b0;
    nFail = 0;
    totalChecks = 0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    // Reset values, unmapped address and write-only clear register
    rd(OFF_STAT, 32'h0000_0100);
    rd(OFF_EN, 32'h0000_0000);
    rd(OFF_C0GRA, 32'h0000_FFFF);
    rd(8'h30, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001);
    rd(OFF_CLR, 32'h0000_0000);
    $display("test reset done");
    // Each mode walks the same pin pattern; wraps give underflow then overflow
    wr(OFF_C0CNT, 32'h0000_0055);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CTRL, 32'h0000_0020 | 32'(modeTab[m]));
      wr(OFF_CLR, 32'h0000_00FF);
      rd(OFF_STAT, 32'h0000_0100);
      wr(OFF_C1CNT, 32'h0000_0000);
      expCnt = 16'h0000;
      for (int s = 0; s < 8; s++) begin
        i_qci_enc_model.move(seqAB[s][1], seqAB[s][0]);
        expCnt = expCnt + 16'(dlt[m][s]);
        rd(OFF_C1CNT, {16'h0000, expCnt});
        if (m == 3 && s == 0) begin
          rd(OFF_STAT, 32'h0000_0082);
        end
      end
      rd(OFF_STAT, (m == 0) ? 32'h0000_0100 : 32'h0000_01C2);
      $display("test mode %0d done", modeTab[m]);
    end
    rd(OFF_C0GRB, 32'h0000_0055);
    // Status is read-only; enables gate requests; priority fixed within a channel
    wr(OFF_STAT, 32'h0000_0000);
    rd(OFF_STAT, 32'h0000_01C2);
    wr(OFF_EN, 32'h0000_0000);
    irqChk(7'h0F);
    wr(OFF_EN, 32'h0000_00C2);
    irqChk(7'h76);
    wr(OFF_CLR, 32'h0000_0040);
    irqChk(7'h77);
    wr(OFF_CLR, 32'h0000_0082);
    irqChk(7'h0F);
    $display("test interrupt done");
    // Timebase matches A and C capture the channel 1 counter
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_C1CNT, 32'h0000_1234);
    wr(OFF_C0CNT, 32'h0000_0000);
    wr(OFF_C0GRA, 32'h0000_0020);
    wr(OFF_C0GRC, 32'h0000_0040);
    wr(OFF_CTRL, 32'h0000_00D0);
    repeat (80) @(posedge mclk);
    wr(OFF_CTRL, 32'h0000_0000);
    rd(OFF_C1GRA, 32'h0000_1234);
    rd(OFF_C1GRB, 32'h0000_1234);
    rd(OFF_STAT, 32'h0000_0135);
    $display("test capture done");
    // Timebase runs past its top; stopped long before match A comes round
    wr(OFF_CLR, 32'h0000_00FF);
    wr(OFF_C0CNT, 32'h0000_FFF8);
    wr(OFF_CTRL, 32'h0000_0010);
    repeat (12) @(posedge mclk);
    wr(OFF_CTRL, 32'h0000_0000);
    rd(OFF_STAT, 32'h0000_0108);
    $display("test overflow done");
    give_verdict();
  end

endmodule : tb_qci_top
